// >>> core/can_acceptance_filter_bank.sv
// Acceptance filter store and comparator behind an AXI4-Lite slave.
// Assumes one clock, synchronous reset, frame identifiers from same clock.
// Contract
// - Upper four bits of the filter 4/5 mode register read zero, writes ignored.
// - The filter 4/5 mode register resets to zero and only software changes it.
// - Bits 3 and 1 select high-half mode of filters 5 and 4, 1 list, 0 mask.
// - Bits 2 and 0 select low-half mode of filters 5 and 4, 1 list, 0 mask.
// - An identifier byte bit gives the expected level, 0 dominant, 1 recessive.
// - A mask bit of 0 leaves that identifier bit out of the comparison.
// - A mask bit of 1 requires the incoming bit to equal the stored level.
// - Each filter owns eight filter bytes whose meaning follows scale and mode.
// - A mask byte uses the same bit mapping as an identifier byte.
// - Filter bytes have no reset value and must be loaded before activation.
// - Each filter has an activation bit and its bytes change only while it is 0.
// - A mode register for filters 0 to 3 holds their half modes, filter 3 high in bit 7.
module can_acceptance_filter_bank #(
  parameter int NUM_FILT = filter_bank_pkg::NUM_FILTERS
) (
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic init_mode_i,
  input wire filter_bank_pkg::frame_id_s frame_i,
  output logic accept_o,
  output logic [7:0] match_index_o,
  output logic result_valid_o
);
  // Only the six-filter map is decoded; other counts are refused here
  if (NUM_FILT != filter_bank_pkg::NUM_FILTERS) begin : g_bad_count
    $error("NUM_FILT must be six");
  end

  // Register window: mode and config words low, then one word per filter
  // byte from the byte base upward; only byte lane 0 carries data, so a
  // write with lane 0 off is answered but stores nothing
  localparam int NB = filter_bank_pkg::BYTES_PER_FILTER;

  logic [7:0] filter_mode_reg_lower;
  logic [filter_bank_pkg::MODE_UPPER_BITS-1:0] filter_mode_reg_upper;
  logic [7:0] filter_config_reg [3];
  logic [7:0] filter_byte_array [NUM_FILT*NB];
  logic [7:0] aw_addr;
  logic aw_held;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic w_held;
  logic [1:0] next_bresp;
  logic [31:0] next_rdata;
  logic [1:0] next_rresp;
  logic [2*NUM_FILT-1:0] half_hit;
  logic [2*NUM_FILT-1:0] half_mode;
  logic [NUM_FILT-1:0] filter_active;
  logic [NUM_FILT-1:0] scale_wide;
  logic do_write;
  logic [5:0] byte_idx;
  logic [2:0] byte_filter;
  logic [7:0] id_count;

  // Write channels accepted independently, one held of each
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      aw_held <= 1'b0;
      aw_addr <= 8'h00;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held <= 1'b1;
      aw_addr <= s_axi_awaddr;
    end else if (do_write) begin
      aw_held <= 1'b0;
    end
  end

  // Write data held with its strobes until the pair is complete
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      w_held <= 1'b0;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held <= 1'b1;
      w_data <= s_axi_wdata;
      w_strb <= s_axi_wstrb;
    end else if (do_write) begin
      w_held <= 1'b0;
    end
  end

  // A held pair waits while the previous response still stands
  assign do_write = aw_held && w_held && !s_axi_bvalid;
  assign byte_idx = 6'((aw_addr - filter_bank_pkg::OFS_BYTES) >> 2);
  assign byte_filter = 3'(byte_idx / 6'(NB));

  // Ready registered so it only rises while the slot is free
  // Held low under a standing response: one write in flight at a time
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
    end else begin
      s_axi_awready <= !aw_held && !s_axi_bvalid && !(s_axi_awvalid && s_axi_awready);
      s_axi_wready <= !w_held && !s_axi_bvalid && !(s_axi_wvalid && s_axi_wready);
    end
  end

  // Decoded write response
  // A refused byte write stores nothing, so software sees why
  always_comb begin
    next_bresp = filter_bank_pkg::RESP_OKAY;
    if (aw_addr >= filter_bank_pkg::OFS_BYTES) begin
      if (byte_idx >= 6'(NUM_FILT*NB) || filter_active[byte_filter]) begin
        next_bresp = filter_bank_pkg::RESP_SLVERR;
      end
    end else if (aw_addr > filter_bank_pkg::OFS_STATUS) begin
      next_bresp = filter_bank_pkg::RESP_SLVERR;
    end
  end

  // Write response, held until the master takes it
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= filter_bank_pkg::RESP_OKAY;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= next_bresp;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Mode registers, software only; hardware never writes them
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      filter_mode_reg_lower <= filter_bank_pkg::MODE_RESET;
      filter_mode_reg_upper <= filter_bank_pkg::MODE_RESET[3:0];
    end else if (do_write && w_strb[0]) begin
      if (aw_addr == filter_bank_pkg::OFS_MODE_LOWER) begin
        filter_mode_reg_lower <= w_data[7:0];
      end
      if (aw_addr == filter_bank_pkg::OFS_MODE_UPPER) begin
        // Only four bits are stored, so the reserved ones cannot be set
        filter_mode_reg_upper <= w_data[3:0];
      end
    end
  end

  // Filter configuration, reserved bits masked off on write
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      for (int i = 0; i < 3; i++) begin
        filter_config_reg[i] <= filter_bank_pkg::CONFIG_RESET;
      end
    end else if (do_write && w_strb[0]) begin
      case (aw_addr)
        filter_bank_pkg::OFS_CONFIG0: begin
          filter_config_reg[0] <= w_data[7:0] & filter_bank_pkg::CONFIG_MASK;
        end
        filter_bank_pkg::OFS_CONFIG1: begin
          filter_config_reg[1] <= w_data[7:0] & filter_bank_pkg::CONFIG_MASK;
        end
        filter_bank_pkg::OFS_CONFIG2: begin
          filter_config_reg[2] <= w_data[7:0] & filter_bank_pkg::CONFIG_MASK;
        end
        default: begin
        end
      endcase
    end
  end

  // Filter bytes: no reset; write dropped while filter active
  // A read before loading returns unknown bits
  always_ff @(posedge clock_i) begin
    if (do_write && w_strb[0] && aw_addr >= filter_bank_pkg::OFS_BYTES &&
        byte_idx < 6'(NUM_FILT*NB) && !filter_active[byte_filter]) begin
      filter_byte_array[byte_idx] <= w_data[7:0];
    end
  end

  // Per-filter fields unpacked from config and mode registers
  // Half h belongs to filter h/2: even h low half, odd h high half
  always_comb begin
    for (int f = 0; f < NUM_FILT; f++) begin
      filter_active[f] = filter_config_reg[f/2][(f%2 == 1) ? filter_bank_pkg::ACT_HI_POS :
        filter_bank_pkg::ACT_LO_POS];
      scale_wide[f] = filter_config_reg[f/2][(f%2 == 1) ? filter_bank_pkg::SCALE_HI_POS + 1 :
        filter_bank_pkg::SCALE_LO_POS + 1];
    end
    half_mode[7:0] = filter_mode_reg_lower;
    half_mode[11:8] = filter_mode_reg_upper;
  end

  // Read path, reserved bits zero
  // Decoded from the address as offered; the capture edge freezes it
  always_comb begin
    next_rdata = 32'h0000_0000;
    next_rresp = filter_bank_pkg::RESP_OKAY;
    case (s_axi_araddr)
      filter_bank_pkg::OFS_MODE_LOWER: next_rdata[7:0] = filter_mode_reg_lower;
      filter_bank_pkg::OFS_MODE_UPPER: next_rdata[3:0] = filter_mode_reg_upper;
      filter_bank_pkg::OFS_CONFIG0: next_rdata[7:0] = filter_config_reg[0];
      filter_bank_pkg::OFS_CONFIG1: next_rdata[7:0] = filter_config_reg[1];
      filter_bank_pkg::OFS_CONFIG2: next_rdata[7:0] = filter_config_reg[2];
      filter_bank_pkg::OFS_STATUS: next_rdata = {23'h000000, init_mode_i, id_count};
      default: begin
        if (s_axi_araddr >= filter_bank_pkg::OFS_BYTES &&
            6'((s_axi_araddr - filter_bank_pkg::OFS_BYTES) >> 2) < 6'(NUM_FILT*NB)) begin
          next_rdata[7:0] = filter_byte_array[6'((s_axi_araddr -
            filter_bank_pkg::OFS_BYTES) >> 2)];
        end else begin
          next_rresp = filter_bank_pkg::RESP_SLVERR;
        end
      end
    endcase
  end

  // Address ready dropped while a read answer stands
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      s_axi_arready <= 1'b0;
    end else begin
      s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
    end
  end

  // Read answer captured at address acceptance, held until taken
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= filter_bank_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= next_rdata;
      s_axi_rresp <= next_rresp;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // One comparator per filter half
  // Wide scale folds the upper identifier word onto the 16-bit compare
  for (genvar h = 0; h < 2*NUM_FILT; h++) begin : g_half
    filter_half_match u_half (
      .id_bytes_i({filter_byte_array[h*4+3], filter_byte_array[h*4+2],
        filter_byte_array[h*4+1], filter_byte_array[h*4]}),
      .frame_id_i(scale_wide[h/2] ? {16'h0000, frame_i.id[31:16]} : frame_i.id),
      .list_mode_i(half_mode[h]),
      .active_i(filter_active[h/2]),
      .hit_o(half_hit[h])
    );
  end

  // Lowest matching half wins; result registered one cycle later
  // Loop runs downward so the last assignment is the lowest hit
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      accept_o <= 1'b0;
      match_index_o <= 8'h00;
      result_valid_o <= 1'b0;
    end else begin
      result_valid_o <= frame_i.valid;
      if (frame_i.valid) begin
        accept_o <= |half_hit;
        match_index_o <= 8'h00;
        for (int h = 2*NUM_FILT-1; h >= 0; h--) begin
          if (half_hit[h]) begin
            match_index_o <= 8'(h);
          end
        end
      end
    end
  end

  // Hit counter for status; wraps at 255, software reads differences
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      id_count <= 8'h00;
    end else if (frame_i.valid && |half_hit) begin
      id_count <= id_count + 8'h01;
    end
  end
endmodule : can_acceptance_filter_bank

// >>> pkg/filter_bank_pkg.sv
// Package for the CAN acceptance filter bank: register map, fields, structs.
// Assumes a 32-bit AXI4-Lite register bus, one register per aligned word.
package filter_bank_pkg;
  // Register byte addresses
  localparam logic [7:0] OFS_MODE_LOWER = 8'h00;
  localparam logic [7:0] OFS_MODE_UPPER = 8'h04;
  localparam logic [7:0] OFS_CONFIG0 = 8'h08;
  localparam logic [7:0] OFS_CONFIG1 = 8'h0C;
  localparam logic [7:0] OFS_CONFIG2 = 8'h10;
  localparam logic [7:0] OFS_ID_LO = 8'h14;
  localparam logic [7:0] OFS_ID_HI = 8'h18;
  localparam logic [7:0] OFS_STATUS = 8'h1C;
  localparam logic [7:0] OFS_BYTES = 8'h40;
  // Reset values
  localparam logic [7:0] MODE_RESET = 8'h00;
  localparam logic [7:0] CONFIG_RESET = 8'h00;
  // Field layout
  localparam int MODE_UPPER_BITS = 4;
  localparam int ACT_LO_POS = 0;
  localparam int ACT_HI_POS = 4;
  localparam int SCALE_LO_POS = 1;
  localparam int SCALE_HI_POS = 5;
  localparam logic [7:0] CONFIG_MASK = 8'h77;
  localparam int NUM_FILTERS = 6;
  localparam int BYTES_PER_FILTER = 8;
  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic [31:0] id;
    logic valid;
  } frame_id_s;
endpackage : filter_bank_pkg

// >>> core/filter_half_match.sv
// One filter half: four filter bytes compared against a frame identifier.
// Assumes bytes and mode are stable while the filter is active.
module filter_half_match (
  input wire logic [31:0] id_bytes_i,
  input wire logic [31:0] frame_id_i,
  input wire logic list_mode_i,
  input wire logic active_i,
  output logic hit_o
);
  logic [15:0] ref_a;
  logic [15:0] ref_b;
  logic [15:0] cmp_b;

  // Bytes 0-1 are identifier, bytes 2-3 mask or second identifier
  always_comb begin
    ref_a = id_bytes_i[15:0];
    ref_b = id_bytes_i[31:16];
    cmp_b = ref_b; // Same bit mapping in both modes
    if (!active_i) begin
      hit_o = 1'b0;
    end else if (list_mode_i) begin
      hit_o = (frame_id_i[15:0] == ref_a) || (frame_id_i[15:0] == cmp_b);
    end else begin
      // Mask bit 0 ignores, 1 must equal stored level
      hit_o = ((frame_id_i[15:0] ^ ref_a) & cmp_b) == 16'h0000;
    end
  end
endmodule : filter_half_match

// >>> tb/filter_bank_props.sv
// Port checker for the acceptance filter bank.
// Assumes it is bound to the bank top, one clock domain.
module filter_bank_props (
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire filter_bank_pkg::frame_id_s frame_i,
  input wire logic result_valid_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clock_i); endclocking
  default disable iff (rst_i);
  // Reserved mode bits read as zero
  a_upper_reads_zero: assert property (
    s_axi_arvalid && s_axi_arready && s_axi_araddr == filter_bank_pkg::OFS_MODE_UPPER
    |=> s_axi_rdata[31:4] == 28'h0) else $error("reserved mode bits not zero");
  // Answers come at fixed distances
  a_read_answer_time: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer not on time");
  a_write_answer_time: assert property (
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
    else $error("write response not on time");
  a_bvalid_release: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write response held too long");
  a_rvalid_release: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read answer held too long");
  // No channel takes a new request while its own answer stands
  a_busy_readies: assert property (s_axi_bvalid || s_axi_rvalid |->
    !(s_axi_bvalid && (s_axi_awready || s_axi_wready)) && !(s_axi_rvalid && s_axi_arready))
    else $error("request taken while busy");
  a_result_follows: assert property (frame_i.valid |=> result_valid_o)
    else $error("no result after frame");
  a_result_cause: assert property (result_valid_o |-> $past(frame_i.valid))
    else $error("result without frame");
endmodule : filter_bank_props

// >>> tb/frame_source.sv
// Bus-side frame source for the filter bank.
// Assumes callers run on the bank clock.
module frame_source (
  input wire logic clock_i,
  output filter_bank_pkg::frame_id_s frame_o
);
  timeunit 1ns;
  timeprecision 1ps;
  initial frame_o = '0;
  // One-cycle valid; id inverted after so a stale id differs from the one sent
  task automatic send(input logic [31:0] id);
    @(posedge clock_i);
    frame_o <= '{id: id, valid: 1'h1};
    @(posedge clock_i);
    frame_o <= '{id: ~id, valid: 1'h0};
  endtask : send
endmodule : frame_source

// >>> tb/test_can_acceptance_filter_bank.sv
// Self-checking bench for the acceptance filter bank.
// Assumes package, design, checker and frame source compiled first.
module test_can_acceptance_filter_bank;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock_i = 1'h0, rst_i = 1'h1, init_mode_i = 1'h1;
  logic [7:0] s_axi_awaddr = 8'h0, s_axi_araddr = 8'h0, match_index_o;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic accept_o, result_valid_o;
  filter_bank_pkg::frame_id_s frame_i;
  logic [7:0] tbl [8] = '{8'h5A, 8'h5A, 8'h3C, 8'h3C, 8'hFF, 8'hFF, 8'hFF, 8'hFF};
  int n_errors = 0, checks = 0;
  always #12.5 clock_i = ~clock_i;
  frame_source src (.clock_i, .frame_o(frame_i));
  can_acceptance_filter_bank DUT (.clock_i, .rst_i, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .init_mode_i, .frame_i,
    .accept_o, .match_index_o, .result_valid_o);
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : end_of_test
  task automatic chk(input logic [33:0] seen, input logic [33:0] exp, input string what);
    checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH %0t %s", $time, what);
    end
  endtask : chk
  // A wait that ran out ends the run
  task automatic guard(input int n);
    if (n >= 40) begin
      n_errors++;
      end_of_test();
    end
  endtask : guard
  // Write cycle; each channel released once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] exp);
    int n;
    @(posedge clock_i);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    for (n = 0; n < 40; n++) begin
      @(posedge clock_i);
      if (s_axi_awready === 1'h1) s_axi_awvalid <= 1'h0;
      if (s_axi_wready === 1'h1) s_axi_wvalid <= 1'h0;
      if (s_axi_bvalid === 1'h1) break;
    end
    guard(n);
    chk({32'h0, s_axi_bresp}, {32'h0, exp}, "write response");
    s_axi_bready <= 1'h0;
  endtask : wr
  // Read cycle; response code and data judged together on OKAY, code alone on an expected error
  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] rexp);
    int n;
    @(posedge clock_i);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    for (n = 0; n < 40; n++) begin
      @(posedge clock_i);
      if (s_axi_arready === 1'h1) s_axi_arvalid <= 1'h0;
      if (s_axi_rvalid === 1'h1) break;
    end
    guard(n);
    if (rexp == filter_bank_pkg::RESP_OKAY) chk({s_axi_rresp, s_axi_rdata}, {rexp, exp}, "rd");
    else chk({32'h0, s_axi_rresp}, {32'h0, rexp}, "read response");
    s_axi_rready <= 1'h0;
  endtask : rd
  // One frame; result sampled mid-cycle where it has settled
  task automatic frame(input logic [31:0] id, input logic hit, input logic [7:0] idx);
    int n;
    src.send(id);
    for (n = 0; n < 40; n++) begin
      @(negedge clock_i);
      if (result_valid_o === 1'h1) break;
    end
    guard(n);
    chk({33'h0, accept_o}, {33'h0, hit}, "accept");
    if (hit) chk({26'h0, match_index_o}, {26'h0, idx}, "match index");
  endtask : frame
  function automatic logic [7:0] fb(input int b);
    return filter_bank_pkg::OFS_BYTES + 8'(4 * (4 * 8 + b));
  endfunction : fb
  task automatic t_reset();
    rd(filter_bank_pkg::OFS_MODE_UPPER, 32'h0, 2'h0);
    rd(filter_bank_pkg::OFS_CONFIG2, 32'h0, 2'h0);
    rd(filter_bank_pkg::OFS_STATUS, 32'h100, 2'h0);
    rd(8'h20, 32'h0, filter_bank_pkg::RESP_SLVERR);
    wr(8'h20, 32'h0, filter_bank_pkg::RESP_SLVERR);
    frame(32'h5A5A, 1'h0, 8'h0);
    $display("test reset done");
  endtask : t_reset
  task automatic t_mode();
    for (int i = 0; i < 4; i++) begin
      wr(filter_bank_pkg::OFS_MODE_UPPER, 32'hF0 | (32'h1 << i), 2'h0);
      rd(filter_bank_pkg::OFS_MODE_UPPER, 32'h1 << i, 2'h0);
    end
    wr(filter_bank_pkg::OFS_MODE_LOWER, 32'hA5, 2'h0);
    rd(filter_bank_pkg::OFS_MODE_LOWER, 32'hA5, 2'h0);
    $display("test mode done");
  endtask : t_mode
  task automatic t_bytes();
    wr(filter_bank_pkg::OFS_CONFIG2, 32'h0, 2'h0);
    for (int b = 0; b < 8; b++) wr(fb(b), {24'h0, tbl[b]}, 2'h0);
    for (int b = 0; b < 8; b++) rd(fb(b), {24'h0, tbl[b]}, 2'h0);
    wr(filter_bank_pkg::OFS_CONFIG2, 32'h1, 2'h0);
    wr(fb(0), 32'h77, filter_bank_pkg::RESP_SLVERR);
    rd(fb(0), 32'h5A, 2'h0);
    $display("test bytes done");
  endtask : t_bytes
  // Filter 4 low half: list mode, then mask mode with mask F0F0
  task automatic t_match();
    wr(filter_bank_pkg::OFS_MODE_UPPER, 32'h3, 2'h0);
    frame(32'h5A5A, 1'h1, 8'h8);
    frame(32'h3C3C, 1'h1, 8'h8);
    frame(32'h5A5B, 1'h0, 8'h0);
    frame(32'hFFFF, 1'h1, 8'h9);
    wr(filter_bank_pkg::OFS_CONFIG2, 32'h0, 2'h0);
    wr(fb(2), 32'hF0, 2'h0);
    wr(fb(3), 32'hF0, 2'h0);
    wr(filter_bank_pkg::OFS_MODE_UPPER, 32'h2, 2'h0);
    wr(filter_bank_pkg::OFS_CONFIG2, 32'h1, 2'h0);
    frame(32'h5555, 1'h1, 8'h8);
    frame(32'h4A5A, 1'h0, 8'h0);
    $display("test match done");
  endtask : t_match
  // Wide scale on filter 4, set while in init mode: upper word compared
  task automatic t_scale();
    wr(filter_bank_pkg::OFS_CONFIG2, 32'h5, 2'h0);
    frame(32'h5555_0000, 1'h1, 8'h8);
    frame(32'h0000_5555, 1'h0, 8'h0);
    @(posedge clock_i);
    init_mode_i <= 1'h0;
    rd(filter_bank_pkg::OFS_STATUS, 32'h5, 2'h0);
    $display("test scale done");
  endtask : t_scale
  initial begin
    repeat (6) @(posedge clock_i);
    rst_i <= 1'h0;
    @(posedge clock_i);
    t_reset();
    t_mode();
    t_bytes();
    t_match();
    t_scale();
    end_of_test();
  end
endmodule : test_can_acceptance_filter_bank
bind can_acceptance_filter_bank filter_bank_props props (.clock_i, .rst_i, .s_axi_araddr,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .s_axi_awvalid,
  .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .frame_i,
  .result_valid_o);
